// ---- inc/i2c_pkg.sv ----
package i2c_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 8;
  // Bus clock made by a master; a quarter period is a least time, so it rounds up
  localparam int BUS_PERIOD_NS = 10000;
  localparam int QUARTER_NS = BUS_PERIOD_NS / 4;
  localparam int QUARTER_CYC = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] QUARTER_CNT = 10'(QUARTER_CYC - 1);
  localparam logic [9:0] HALF_CNT = 10'(2 * QUARTER_CYC - 1);

  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam int ADDR_W = 7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_END = 4'h9;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ADDR = 2'b01,
    PH_DATA = 2'b10
  } phase_t;

  typedef enum logic [2:0] {
    GEN_IDLE = 3'b000,
    GEN_START = 3'b001,
    GEN_LOW = 3'b010,
    GEN_HIGH = 3'b011,
    GEN_STOP = 3'b100,
    GEN_STOP_HI = 3'b101,
    GEN_RESTART = 3'b110,
    GEN_RS_HI = 3'b111
  } gen_t;

  // Which end puts bits on the data line for the current byte
  function automatic logic drives_byte(input logic master, input logic read,
                                       input logic addr);
    return addr ? master : (master ^ read);
  endfunction

endpackage

// ---- inc/i2c_link_if.sv ----
`timescale 1ns/1ps
interface i2c_link_if;

  // ****************************************************************
  // Open-drain pins of both ends and the resolved wired-AND lines
  // ****************************************************************
  logic dev_scl_out;
  logic dev_scl_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic far_scl_out;
  logic far_scl_oe;
  logic far_sda_out;
  logic far_sda_oe;
  logic scl_in;
  logic sda_in;

  // Released line floats high through the pull-up
  assign scl_in = ~((dev_scl_oe & ~dev_scl_out) | (far_scl_oe & ~far_scl_out));
  assign sda_in = ~((dev_sda_oe & ~dev_sda_out) | (far_sda_oe & ~far_sda_out));

  modport device (input scl_in, input sda_in, output dev_scl_out, output dev_scl_oe,
                  output dev_sda_out, output dev_sda_oe);
  modport far (input scl_in, input sda_in, output far_scl_out, output far_scl_oe,
               output far_sda_out, output far_sda_oe);

endinterface

// ---- rtl/partner_bus_node.sv ----
`timescale 1ns/1ps
module partner_bus_node import i2c_pkg::*; (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  i2c_link_if.far LINK,
  input wire logic MASTER_MODE_IN,
  input wire logic XFER_REQ_IN,
  input wire logic [ADDR_W-1:0] TARGET_ADDR_IN,
  input wire logic READ_IN,
  input wire logic [7:0] TX_DATA_IN,
  input wire logic LAST_IN,
  input wire logic RESTART_IN,
  input wire logic [ADDR_W-1:0] OWN_ADDR_IN,
  output logic [7:0] RX_DATA_OUT,
  output logic RX_VALID_OUT,
  output logic TX_TAKEN_OUT,
  output logic ACK_ERR_OUT,
  output logic BUSY_OUT
);

  // ****************************************************************
  // Line sampling
  // ****************************************************************
  logic scl_m_reg, scl_s_reg, scl_p_reg, sda_m_reg, sda_s_reg, sda_p_reg;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic bus_busy_reg;

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      {scl_m_reg, scl_s_reg, scl_p_reg} <= 3'h7;
      {sda_m_reg, sda_s_reg, sda_p_reg} <= 3'h7;
    end else begin
      {scl_m_reg, scl_s_reg, scl_p_reg} <= {LINK.scl_in, scl_m_reg, scl_s_reg};
      {sda_m_reg, sda_s_reg, sda_p_reg} <= {LINK.sda_in, sda_m_reg, sda_s_reg};
    end
  end

  assign scl_rise = scl_s_reg & ~scl_p_reg;
  assign scl_fall = ~scl_s_reg & scl_p_reg;
  assign start_det = scl_s_reg & scl_p_reg & sda_p_reg & ~sda_s_reg;
  assign stop_det = scl_s_reg & scl_p_reg & ~sda_p_reg & sda_s_reg;

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      bus_busy_reg <= 1'b0;
    end else if (start_det) begin
      bus_busy_reg <= 1'b1;
    end else if (stop_det) begin
      bus_busy_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Bus clock and Start/Stop generator
  // ****************************************************************
  gen_t gen_reg;
  logic [9:0] q_cnt_reg;
  logic scl_low_reg, gen_sda_low_reg, end_req_reg, end_restart_reg;

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      gen_reg <= GEN_IDLE;
      q_cnt_reg <= '0;
      scl_low_reg <= 1'b0;
      gen_sda_low_reg <= 1'b0;
    end else begin
      q_cnt_reg <= q_cnt_reg + 10'h001;
      case (gen_reg)
        GEN_IDLE: begin
          q_cnt_reg <= '0;
          if (MASTER_MODE_IN && XFER_REQ_IN && !bus_busy_reg && scl_s_reg && sda_s_reg) begin
            gen_sda_low_reg <= 1'b1;
            gen_reg <= GEN_START;
          end
        end
        GEN_START: if (q_cnt_reg == QUARTER_CNT) begin
          q_cnt_reg <= '0;
          scl_low_reg <= 1'b1;
          gen_sda_low_reg <= 1'b0;
          gen_reg <= GEN_LOW;
        end
        GEN_LOW: if (end_req_reg) begin
          q_cnt_reg <= '0;
          gen_sda_low_reg <= ~end_restart_reg;
          gen_reg <= end_restart_reg ? GEN_RESTART : GEN_STOP;
        end else if (q_cnt_reg == HALF_CNT) begin
          q_cnt_reg <= '0;
          scl_low_reg <= 1'b0;
          gen_reg <= GEN_HIGH;
        end
        GEN_HIGH: if (q_cnt_reg == HALF_CNT) begin
          q_cnt_reg <= '0;
          scl_low_reg <= 1'b1;
          gen_reg <= GEN_LOW;
        end
        GEN_STOP: if (q_cnt_reg == QUARTER_CNT) begin
          q_cnt_reg <= '0;
          scl_low_reg <= 1'b0;
          gen_reg <= GEN_STOP_HI;
        end
        GEN_STOP_HI: if (q_cnt_reg == QUARTER_CNT) begin
          gen_sda_low_reg <= 1'b0;
          gen_reg <= GEN_IDLE;
        end
        GEN_RESTART: if (q_cnt_reg == QUARTER_CNT) begin
          q_cnt_reg <= '0;
          scl_low_reg <= 1'b0;
          gen_reg <= GEN_RS_HI;
        end
        GEN_RS_HI: if (q_cnt_reg == QUARTER_CNT) begin
          q_cnt_reg <= '0;
          gen_sda_low_reg <= 1'b1;
          gen_reg <= GEN_START;
        end
        default: gen_reg <= GEN_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Byte engine
  // ****************************************************************
  phase_t phase_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shreg_reg;
  logic master_reg, read_reg, ack_reg, last_reg, sda_low_reg;

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      phase_reg <= PH_IDLE;
      bit_cnt_reg <= '0;
      shreg_reg <= '0;
      {master_reg, read_reg, ack_reg, last_reg, sda_low_reg} <= 5'h00;
      RX_DATA_OUT <= '0;
      {RX_VALID_OUT, TX_TAKEN_OUT, ACK_ERR_OUT, end_req_reg, end_restart_reg} <= 5'h00;
    end else begin
      {RX_VALID_OUT, TX_TAKEN_OUT, ACK_ERR_OUT, end_req_reg} <= 4'h0;
      if (start_det) begin
        phase_reg <= PH_ADDR;
        bit_cnt_reg <= '0;
        sda_low_reg <= 1'b0;
        master_reg <= (gen_reg != GEN_IDLE);
        shreg_reg <= {TARGET_ADDR_IN, READ_IN};
      end else if (stop_det) begin
        phase_reg <= PH_IDLE;
        sda_low_reg <= 1'b0;
      end else if (phase_reg != PH_IDLE) begin
        if (scl_rise && bit_cnt_reg < BYTE_BITS) begin
          shreg_reg <= {shreg_reg[6:0], sda_s_reg};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end else if (scl_rise && bit_cnt_reg == BYTE_BITS) begin
          ack_reg <= sda_s_reg;
          bit_cnt_reg <= ACK_END;
        end else if (scl_fall && bit_cnt_reg < BYTE_BITS) begin
          sda_low_reg <= drives_byte(master_reg, read_reg, phase_reg == PH_ADDR)
                         & ~shreg_reg[7];
        end else if (scl_fall && bit_cnt_reg == BYTE_BITS) begin
          last_reg <= LAST_IN;
          if (phase_reg == PH_ADDR) begin
            read_reg <= shreg_reg[0];
            if (master_reg) begin
              sda_low_reg <= 1'b0;
            end else if (shreg_reg[7:1] == OWN_ADDR_IN) begin
              sda_low_reg <= 1'b1;
            end else begin
              phase_reg <= PH_IDLE;
            end
          end else if (!drives_byte(master_reg, read_reg, 1'b0)) begin
            RX_DATA_OUT <= shreg_reg;
            RX_VALID_OUT <= 1'b1;
            sda_low_reg <= ~(master_reg & LAST_IN);
          end else begin
            sda_low_reg <= 1'b0;
          end
        end else if (scl_fall) begin
          bit_cnt_reg <= '0;
          phase_reg <= PH_DATA;
          if (master_reg && ((ack_reg && (phase_reg == PH_ADDR || !read_reg)) ||
              (last_reg && phase_reg == PH_DATA))) begin
            ACK_ERR_OUT <= ack_reg & ~(last_reg & read_reg);
            phase_reg <= PH_IDLE;
            sda_low_reg <= 1'b0;
            end_req_reg <= 1'b1;
            end_restart_reg <= RESTART_IN;
          end else if (!master_reg && read_reg && ack_reg && phase_reg == PH_DATA) begin
            phase_reg <= PH_IDLE;
            sda_low_reg <= 1'b0;
          end else if (master_reg ^ read_reg) begin
            shreg_reg <= TX_DATA_IN;
            sda_low_reg <= ~TX_DATA_IN[7];
            TX_TAKEN_OUT <= 1'b1;
          end else begin
            sda_low_reg <= 1'b0;
          end
        end
      end
    end
  end

  // ****************************************************************
  // Pins: pull low or release, never drive high
  // ****************************************************************
  assign LINK.far_scl_out = 1'b0;
  assign LINK.far_sda_out = 1'b0;
  assign LINK.far_scl_oe = scl_low_reg;
  assign LINK.far_sda_oe = sda_low_reg | gen_sda_low_reg;
  assign BUSY_OUT = (gen_reg != GEN_IDLE) | (phase_reg != PH_IDLE);

endmodule

// ---- rtl/sync_serial_port_unit.sv ----
`timescale 1ns/1ps
// Overview of operation
// - Lines only pulled low or released
// - Master and slave, transmit and receive roles
// - Master opens with Start then address
// - Direction bit follows the slave address
// - Matching slave acknowledges; data then flows
// - Receiving master ends without final acknowledge
// - Stop is data rising with clock high
// - Repeated Start may replace Stop
// - Dedicated pins ignore per-pin threshold selection
module sync_serial_port_unit import i2c_pkg::*; (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  i2c_link_if.device LINK,
  input wire logic MASTER_MODE_IN,
  input wire logic XFER_REQ_IN,
  input wire logic [ADDR_W-1:0] TARGET_ADDR_IN,
  input wire logic READ_IN,
  input wire logic [7:0] TX_DATA_IN,
  input wire logic LAST_IN,
  input wire logic RESTART_IN,
  input wire logic [ADDR_W-1:0] OWN_ADDR_IN,
  input wire logic DEDICATED_PINS_IN,
  input wire logic PIN_INPUT_THRESHOLD_SELECT_IN,
  output logic THRESHOLD_SEL_OUT,
  output logic [7:0] RX_DATA_OUT,
  output logic RX_VALID_OUT,
  output logic TX_TAKEN_OUT,
  output logic ACK_ERR_OUT,
  output logic BUSY_OUT,
  output logic [1:0] ROLE_OUT
);

  // ****************************************************************
  // Line sampling
  // ****************************************************************
  logic scl_m_reg, scl_s_reg, scl_p_reg, sda_m_reg, sda_s_reg, sda_p_reg;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic bus_busy_reg;

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      {scl_m_reg, scl_s_reg, scl_p_reg} <= 3'h7;
      {sda_m_reg, sda_s_reg, sda_p_reg} <= 3'h7;
    end else begin
      {scl_m_reg, scl_s_reg, scl_p_reg} <= {LINK.scl_in, scl_m_reg, scl_s_reg};
      {sda_m_reg, sda_s_reg, sda_p_reg} <= {LINK.sda_in, sda_m_reg, sda_s_reg};
    end
  end

  assign scl_rise = scl_s_reg & ~scl_p_reg;
  assign scl_fall = ~scl_s_reg & scl_p_reg;
  // Both samples must see the clock high, so a data change while the clock is low
  // never looks like a Start or Stop
  assign start_det = scl_s_reg & scl_p_reg & sda_p_reg & ~sda_s_reg;
  assign stop_det = scl_s_reg & scl_p_reg & ~sda_p_reg & sda_s_reg;

  // Another master owns the bus from its Start to its Stop
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      bus_busy_reg <= 1'b0;
    end else if (start_det) begin
      bus_busy_reg <= 1'b1;
    end else if (stop_det) begin
      bus_busy_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Input threshold selection
  // ****************************************************************
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      THRESHOLD_SEL_OUT <= 1'b0;
    end else begin
      THRESHOLD_SEL_OUT <= ~DEDICATED_PINS_IN & PIN_INPUT_THRESHOLD_SELECT_IN;
    end
  end

  // ****************************************************************
  // Bus clock and Start/Stop generator
  // ****************************************************************
  gen_t gen_reg;
  logic [9:0] q_cnt_reg;
  logic scl_low_reg, gen_sda_low_reg, end_req_reg, end_restart_reg;

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      gen_reg <= GEN_IDLE;
      q_cnt_reg <= '0;
      scl_low_reg <= 1'b0;
      gen_sda_low_reg <= 1'b0;
    end else begin
      q_cnt_reg <= q_cnt_reg + 10'h001;
      case (gen_reg)
        GEN_IDLE: begin
          q_cnt_reg <= '0;
          if (MASTER_MODE_IN && XFER_REQ_IN && !bus_busy_reg && scl_s_reg && sda_s_reg) begin
            gen_sda_low_reg <= 1'b1;
            gen_reg <= GEN_START;
          end
        end
        GEN_START: if (q_cnt_reg == QUARTER_CNT) begin
          q_cnt_reg <= '0;
          scl_low_reg <= 1'b1;
          gen_sda_low_reg <= 1'b0;
          gen_reg <= GEN_LOW;
        end
        // The byte engine asks to finish while the clock is still low
        GEN_LOW: if (end_req_reg) begin
          q_cnt_reg <= '0;
          gen_sda_low_reg <= ~end_restart_reg;
          gen_reg <= end_restart_reg ? GEN_RESTART : GEN_STOP;
        end else if (q_cnt_reg == HALF_CNT) begin
          q_cnt_reg <= '0;
          scl_low_reg <= 1'b0;
          gen_reg <= GEN_HIGH;
        end
        // A slave holding the clock low stretches the high phase count
        GEN_HIGH: if (!scl_s_reg) begin
          q_cnt_reg <= '0;
        end else if (q_cnt_reg == HALF_CNT) begin
          q_cnt_reg <= '0;
          scl_low_reg <= 1'b1;
          gen_reg <= GEN_LOW;
        end
        GEN_STOP: if (q_cnt_reg == QUARTER_CNT) begin
          q_cnt_reg <= '0;
          scl_low_reg <= 1'b0;
          gen_reg <= GEN_STOP_HI;
        end
        GEN_STOP_HI: if (!scl_s_reg) begin
          q_cnt_reg <= '0;
        end else if (q_cnt_reg == QUARTER_CNT) begin
          gen_sda_low_reg <= 1'b0;
          gen_reg <= GEN_IDLE;
        end
        GEN_RESTART: if (q_cnt_reg == QUARTER_CNT) begin
          q_cnt_reg <= '0;
          scl_low_reg <= 1'b0;
          gen_reg <= GEN_RS_HI;
        end
        GEN_RS_HI: if (!scl_s_reg) begin
          q_cnt_reg <= '0;
        end else if (q_cnt_reg == QUARTER_CNT) begin
          q_cnt_reg <= '0;
          gen_sda_low_reg <= 1'b1;
          gen_reg <= GEN_START;
        end
        default: gen_reg <= GEN_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Byte engine shared by all four roles
  // ****************************************************************
  phase_t phase_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shreg_reg;
  logic master_reg, read_reg, ack_reg, last_reg, sda_low_reg;

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      phase_reg <= PH_IDLE;
      bit_cnt_reg <= '0;
      shreg_reg <= '0;
      {master_reg, read_reg, ack_reg, last_reg, sda_low_reg} <= 5'h00;
      RX_DATA_OUT <= '0;
      {RX_VALID_OUT, TX_TAKEN_OUT, ACK_ERR_OUT, end_req_reg, end_restart_reg} <= 5'h00;
    end else begin
      {RX_VALID_OUT, TX_TAKEN_OUT, ACK_ERR_OUT, end_req_reg} <= 4'h0;
      if (start_det) begin
        // A Start that our own generator made puts us in a master role
        phase_reg <= PH_ADDR;
        bit_cnt_reg <= '0;
        sda_low_reg <= 1'b0;
        master_reg <= (gen_reg != GEN_IDLE);
        shreg_reg <= {TARGET_ADDR_IN, READ_IN};
      end else if (stop_det) begin
        phase_reg <= PH_IDLE;
        sda_low_reg <= 1'b0;
      end else if (phase_reg != PH_IDLE) begin
        if (scl_rise && bit_cnt_reg < BYTE_BITS) begin
          shreg_reg <= {shreg_reg[6:0], sda_s_reg};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end else if (scl_rise && bit_cnt_reg == BYTE_BITS) begin
          ack_reg <= sda_s_reg;
          bit_cnt_reg <= ACK_END;
        end else if (scl_fall && bit_cnt_reg < BYTE_BITS) begin
          sda_low_reg <= drives_byte(master_reg, read_reg, phase_reg == PH_ADDR)
                         & ~shreg_reg[7];
        end else if (scl_fall && bit_cnt_reg == BYTE_BITS) begin
          last_reg <= LAST_IN;
          if (phase_reg == PH_ADDR) begin
            read_reg <= shreg_reg[0];
            if (master_reg) begin
              sda_low_reg <= 1'b0;
            end else if (shreg_reg[7:1] == OWN_ADDR_IN) begin
              sda_low_reg <= 1'b1;
            end else begin
              phase_reg <= PH_IDLE;
            end
          end else if (!drives_byte(master_reg, read_reg, 1'b0)) begin
            RX_DATA_OUT <= shreg_reg;
            RX_VALID_OUT <= 1'b1;
            // Receiving master leaves the last acknowledge released and then ends
            sda_low_reg <= ~(master_reg & LAST_IN);
          end else begin
            sda_low_reg <= 1'b0;
          end
        end else if (scl_fall) begin
          bit_cnt_reg <= '0;
          phase_reg <= PH_DATA;
          if (master_reg && ((ack_reg && (phase_reg == PH_ADDR || !read_reg)) ||
              (last_reg && phase_reg == PH_DATA))) begin
            ACK_ERR_OUT <= ack_reg & ~(last_reg & read_reg);
            phase_reg <= PH_IDLE;
            sda_low_reg <= 1'b0;
            end_req_reg <= 1'b1;
            end_restart_reg <= RESTART_IN;
          end else if (!master_reg && read_reg && ack_reg && phase_reg == PH_DATA) begin
            phase_reg <= PH_IDLE;
            sda_low_reg <= 1'b0;
          end else if (master_reg ^ read_reg) begin
            shreg_reg <= TX_DATA_IN;
            sda_low_reg <= ~TX_DATA_IN[7];
            TX_TAKEN_OUT <= 1'b1;
          end else begin
            sda_low_reg <= 1'b0;
          end
        end
      end
    end
  end

  // ****************************************************************
  // Pins: pull low or release, never drive high
  // ****************************************************************
  assign LINK.dev_scl_out = 1'b0;
  assign LINK.dev_sda_out = 1'b0;
  assign LINK.dev_scl_oe = scl_low_reg;
  assign LINK.dev_sda_oe = sda_low_reg | gen_sda_low_reg;
  assign BUSY_OUT = (gen_reg != GEN_IDLE) | (phase_reg != PH_IDLE);
  assign ROLE_OUT = {master_reg, read_reg};

endmodule

// ---- tb/i2c_bus_signaling_props.sv ----
`timescale 1ns/1ps
module i2c_bus_signaling_props import i2c_pkg::*; (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic dev_scl_out,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe,
  input wire logic far_scl_out,
  input wire logic far_scl_oe,
  input wire logic far_sda_out,
  input wire logic far_sda_oe,
  input wire logic scl_in,
  input wire logic sda_in
);
  localparam int QMIN = 300;
  localparam int QMAX = 330;
  // ********
  // Low phase length
  // ********
  logic [15:0] low_cnt_reg;
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN || scl_in) begin
      low_cnt_reg <= 16'h0000;
    end else if (low_cnt_reg != 16'hffff) begin
      low_cnt_reg <= low_cnt_reg + 16'h0001;
    end
  end
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);
  // ********
  // Line rules
  // ********
  chk_dev_open_drain: assert property (!dev_scl_out && !dev_sda_out)
    else $error("device drives a line high");
  chk_far_open_drain: assert property (!far_scl_out && !far_sda_out)
    else $error("partner drives a line high");
  chk_start_hold: assert property ($fell(sda_in) && scl_in |-> scl_in [*8])
    else $error("clock not held high after start");
  chk_start_clock: assert property ($fell(sda_in) && scl_in |-> ##[QMIN:QMAX] $fell(scl_in))
    else $error("first clock fall after start mistimed");
  chk_stop_hold: assert property ($rose(sda_in) && scl_in |-> sda_in [*8])
    else $error("data not held high after stop");
  chk_stop_free: assert property ($rose(sda_in) && scl_in |->
      (!dev_sda_oe && !far_sda_oe && !dev_scl_oe && !far_scl_oe) [*4])
    else $error("line still pulled after stop");
  chk_bit_stable: assert property ($rose(scl_in) |-> $stable(sda_in) [*8])
    else $error("data moved at clock rise");
  chk_scl_low_time: assert property ($rose(scl_in) |-> low_cnt_reg >= 16'(QUARTER_CYC - 2))
    else $error("clock low phase too short");
  cov_start: cover property ($fell(sda_in) && scl_in);
  cov_stop: cover property ($rose(sda_in) && scl_in);
  cov_slave_ack: cover property (dev_scl_oe && far_sda_oe);
endmodule

// ---- tb/i2c_bus_signaling_tb.sv ----
`timescale 1ns/1ps
module i2c_bus_signaling_tb;
  localparam logic [6:0] DEV_ADDR = 7'h2a;
  localparam logic [6:0] FAR_ADDR = 7'h55;
  logic clk, rst, ded, thr_sel, thr_out, dev_mm;
  logic dev_req, dev_rd, dev_last, dev_rs, dev_rxv, dev_taken, dev_err, dev_busy;
  logic far_req, far_rd, far_last, far_rs, far_rxv, far_taken, far_err, far_busy;
  logic [6:0] dev_tgt, far_tgt;
  logic [7:0] dev_tx, far_tx, dev_rx, far_rx;
  logic [1:0] role;
  int miscompares, check_count, cycles, err_pulses, taken_pulses, rxv_pulses;
  i2c_link_if link_inst ();
  sync_serial_port_unit sync_serial_port_unit_inst (.CORE_CLK_IN(clk), .RST_IN(rst),
    .LINK(link_inst.device), .MASTER_MODE_IN(dev_mm), .XFER_REQ_IN(dev_req),
    .TARGET_ADDR_IN(dev_tgt), .READ_IN(dev_rd), .TX_DATA_IN(dev_tx), .LAST_IN(dev_last),
    .RESTART_IN(dev_rs), .OWN_ADDR_IN(DEV_ADDR), .DEDICATED_PINS_IN(ded),
    .PIN_INPUT_THRESHOLD_SELECT_IN(thr_sel), .THRESHOLD_SEL_OUT(thr_out),
    .RX_DATA_OUT(dev_rx), .RX_VALID_OUT(dev_rxv), .TX_TAKEN_OUT(dev_taken),
    .ACK_ERR_OUT(dev_err), .BUSY_OUT(dev_busy), .ROLE_OUT(role));
  partner_bus_node partner_bus_node_inst (.CORE_CLK_IN(clk), .RST_IN(rst),
    .LINK(link_inst.far), .MASTER_MODE_IN(1'b1), .XFER_REQ_IN(far_req),
    .TARGET_ADDR_IN(far_tgt), .READ_IN(far_rd), .TX_DATA_IN(far_tx), .LAST_IN(far_last),
    .RESTART_IN(far_rs), .OWN_ADDR_IN(FAR_ADDR), .RX_DATA_OUT(far_rx),
    .RX_VALID_OUT(far_rxv), .TX_TAKEN_OUT(far_taken), .ACK_ERR_OUT(far_err),
    .BUSY_OUT(far_busy));
  i2c_bus_signaling_props props_inst (.CORE_CLK_IN(clk), .RST_IN(rst),
    .dev_scl_out(link_inst.dev_scl_out), .dev_scl_oe(link_inst.dev_scl_oe),
    .dev_sda_out(link_inst.dev_sda_out), .dev_sda_oe(link_inst.dev_sda_oe),
    .far_scl_out(link_inst.far_scl_out), .far_scl_oe(link_inst.far_scl_oe),
    .far_sda_out(link_inst.far_sda_out), .far_sda_oe(link_inst.far_sda_oe),
    .scl_in(link_inst.scl_in), .sda_in(link_inst.sda_in));
  // ********
  // Helpers
  // ********
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp, input string what);
    cmp_byte({7'h00, got}, {7'h00, exp}, what);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Counts bus clock falls; the bench keys LAST and RESTART to them
  task automatic falls(input int n);
    repeat (n) @(negedge link_inst.scl_in);
    tick(1);
  endtask
  task automatic go(input logic far_side);
    int n;
    n = 0;
    // The ends have no bus-free timer, so the bench leaves the bus idle after a Stop
    tick(16);
    dev_req = !far_side;
    far_req = far_side;
    while ((dev_busy | far_busy) !== 1'b1 && n < 1000) begin
      tick(1);
      n++;
    end
    dev_req = 1'b0;
    far_req = 1'b0;
    cmp_flag(dev_busy | far_busy, 1'b1, "request taken");
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while ((dev_busy | far_busy) !== 1'b0 && n < 60000) begin
      tick(1);
      n++;
    end
    cmp_flag(dev_busy | far_busy, 1'b0, "bus idle");
  endtask
  // ********
  // Scenarios
  // ********
  task automatic thresholds;
    for (int i = 0; i < 4; i++) begin
      ded = i[1];
      thr_sel = i[0];
      tick(2);
      cmp_flag(thr_out, !i[1] && i[0], "threshold select");
    end
  endtask
  task automatic write_restart_read;
    dev_tgt = FAR_ADDR;
    dev_tx = 8'ha5;
    far_tx = 8'h3c;
    dev_rs = 1'b1;
    go(1'b0);
    falls(5);
    cmp_byte({6'h00, role}, 8'h02, "role master tx");
    falls(5);
    dev_last = 1'b1;
    falls(9);
    dev_rd = 1'b1;
    cmp_byte(far_rx, 8'ha5, "slave got byte");
    falls(1);
    dev_rs = 1'b0;
    dev_last = 1'b0;
    falls(8);
    tick(4);
    cmp_byte({6'h00, role}, 8'h03, "role master rx after restart");
    dev_last = 1'b1;
    falls(9);
    tick(700);
    cmp_flag(link_inst.sda_in, 1'b1, "last ack slot released");
    wait_idle;
    cmp_byte(dev_rx, 8'h3c, "master read byte");
    cmp_byte(8'(err_pulses), 8'h00, "no nack seen");
    cmp_byte(8'(taken_pulses), 8'h02, "bytes loaded");
    cmp_byte(8'(rxv_pulses), 8'h02, "bytes received");
  endtask
  task automatic slave_transmit;
    far_tgt = DEV_ADDR;
    far_rd = 1'b1;
    dev_tx = 8'hc3;
    go(1'b1);
    falls(9);
    tick(4);
    cmp_byte({6'h00, role}, 8'h01, "role slave tx");
    far_last = 1'b1;
    wait_idle;
    cmp_byte(far_rx, 8'hc3, "partner read byte");
    cmp_byte(8'(taken_pulses), 8'h03, "slave byte loaded");
    cmp_byte(8'(rxv_pulses), 8'h03, "partner byte received");
  endtask
  task automatic wrong_address;
    dev_tgt = 7'h11;
    dev_rd = 1'b0;
    dev_last = 1'b0;
    go(1'b0);
    wait_idle;
    cmp_byte(8'(err_pulses), 8'h01, "nack flagged");
    cmp_byte(far_rx, 8'hc3, "unaddressed slave untouched");
  endtask
  task automatic master_off;
    dev_mm = 1'b0;
    dev_req = 1'b1;
    tick(20);
    cmp_flag(dev_busy, 1'b0, "request ignored without master mode");
    dev_req = 1'b0;
    dev_mm = 1'b1;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Each full run needs about 83k cycles; the ceiling leaves some slack
  always @(posedge clk) begin
    cycles++;
    if (dev_err === 1'b1 || far_err === 1'b1) begin
      err_pulses++;
    end
    if (dev_taken === 1'b1 || far_taken === 1'b1) begin
      taken_pulses++;
    end
    if (dev_rxv === 1'b1 || far_rxv === 1'b1) begin
      rxv_pulses++;
    end
    if (cycles == 99000) begin
      miscompares++;
      $display("MISMATCH at %0t: timeout", $time);
      wrap_up;
    end
  end
  initial begin
    {rst, ded, thr_sel, dev_req, dev_rd, dev_last, dev_rs} = 7'h7f & 7'h40;
    dev_mm = 1'b1;
    {far_req, far_rd, far_last, far_rs} = 4'h0;
    {dev_tgt, far_tgt, dev_tx, far_tx} = '0;
    tick(8);
    rst = 1'b0;
    tick(3);
    thresholds;
    master_off;
    write_restart_read;
    slave_transmit;
    wrong_address;
    wrap_up;
  end
endmodule
